/* File: mem_consts.vh */
// Address map, bus roles and timing constants for the on-chip memory decoder
`ifndef MEM_CONSTS_VH
`define MEM_CONSTS_VH

// Bus geometry
`define NBUS 5
`define AW 24
`define DW 16
`define BIDX_W 3

// Bus roles, in falling priority order
`define BUS_PROG 3'h0
`define BUS_RD_C 3'h1
`define BUS_RD_D 3'h2
`define BUS_WR 3'h3
`define BUS_DMA 3'h4
`define BUS_WR_MASK 5'h18
`define BUS_ROM_MASK 5'h07

// Dual-access RAM: eight 4K-word blocks in the lowest 64K bytes
`define RAM_PAGE 8'h00
`define RAM_BLOCKS 8
`define RAM_WORD_W 12
`define RAM_BLK_LSB 13
`define RAM_WORD_LSB 1

// ROM window FF8000h..FFFFFFh, byte offsets inside the 32K-byte window
`define ROM_PAGE 9'h1FF
`define ROM_OFF_REV 15'h6CAE
`define ROM_OFF_BRANCH 15'h6CB0
`define ROM_OFF_SINE 15'h6D00
`define ROM_OFF_RSVD 15'h6F00
`define ROM_OFF_VEC 15'h7F00
`define ROM_FILL_WORD 16'h0000
`define ROM_RSVD_WORD 16'h0000

// ROM timing: wait cycles added to the two-cycle minimum from request to acknowledge
`define ROM_FIRST_CYC 2'h2
`define ROM_SEQ_CYC 2'h0
`define ROM_SEQ_GRACE 2'h2
`define ROM_STEP 24'h000002

// Boot-mode strap codes that disable the ROM, and the selector value at reset
`define STRAP_EXT16 3'h0
`define STRAP_EXT32 3'h4
`define SEL_RESET 1'b1

`endif

/* File: ram_block.v */
// One dual-access RAM block: two independent ports, registered read data
`timescale 1ns/1ps
module ram_block #(
    parameter AW = 12,
    parameter DW = 16
)(
    input wire clk_sys,
    input wire a_en,
    input wire a_we,
    input wire [AW-1:0] a_addr,
    input wire [DW-1:0] a_wdata,
    output reg [DW-1:0] a_rdata_r,
    input wire b_en,
    input wire b_we,
    input wire [AW-1:0] b_addr,
    input wire [DW-1:0] b_wdata,
    output reg [DW-1:0] b_rdata_r
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // Both ports act in the same cycle; on a write collision port B wins
    always @(posedge clk_sys) begin
        if (a_en && a_we) begin
            mem[a_addr] <= a_wdata;
        end
        if (b_en && b_we) begin
            mem[b_addr] <= b_wdata;
        end
    end

    // Read-before-write: a read beside a write sees the old word
    always @(posedge clk_sys) begin
        if (a_en) begin
            a_rdata_r <= mem[a_addr];
        end
        if (b_en) begin
            b_rdata_r <= mem[b_addr];
        end
    end
endmodule

/* File: onchip_memory_decoder.v */
// On-chip memory decoder: ROM window, dual-access RAM blocks, external path
//
// Operation
// - Program and data accesses decode against one shared address space.
// - Provide a 16K x16 read-only memory mapped into program space.
// - Selector 0 routes FF8000h upward to the on-chip ROM.
// - Selector 1 removes ROM; that range goes to external memory.
// - Straps 00h or 04h set selector to 1, else clear it.
// - Straps are sampled only at hardware reset, then ignored.
// - Software reset leaves the selector unchanged.
// - Software may write the selector; decoding follows the new value.
// - ROM accepts reads from program bus and both read data buses.
// - ROM word takes two cycles, first word of a sequence four.
// - ROM layout: loader, revision, branch table, sine, reserved, vectors.
// - ROM holds a 256-entry full-turn Q15 sine table.
// - 32K x16 dual-access RAM maps to the lowest 64K bytes.
// - RAM is eight 4K-word blocks, each an 8K-byte range.
// - Each RAM block serves two accesses per cycle without stalling.
// - RAM accepts program, data and DMA bus accesses.
// - Host-port accesses to RAM are refused while held in reset.
// - Boot-mode straps are captured at release of hardware reset.
`timescale 1ns/1ps
`include "mem_consts.vh"
module onchip_memory_decoder #(
    parameter [15:0] LOADER_REV = 16'h0000, // Arbitrary revision code
    parameter [15:0] BRANCH_BASE = 16'h0000
)(
    input wire clk_sys,
    input wire reset,
    input wire core_in_reset,
    input wire soft_reset,
    input wire [2:0] boot_mode_straps,
    input wire core_status_word_three_wr,
    input wire core_status_word_three_sel,
    input wire [`NBUS-1:0] bus_req,
    input wire [`NBUS-1:0] bus_we,
    input wire [`NBUS*`AW-1:0] bus_addr,
    input wire [`NBUS*`DW-1:0] bus_wdata,
    input wire dma_from_host_port,
    output reg [`NBUS-1:0] bus_ack_r,
    output reg [`NBUS-1:0] bus_err_r,
    output reg [`NBUS*`DW-1:0] bus_rdata_r,
    output reg ext_req_r,
    output reg ext_we_r,
    output reg [`AW-1:0] ext_addr_r,
    output reg [`DW-1:0] ext_wdata_r,
    output reg [`BIDX_W-1:0] ext_tag_r,
    input wire ext_ack,
    input wire [`BIDX_W-1:0] ext_ack_tag,
    input wire [`DW-1:0] ext_rdata,
    output reg rom_disable_select_r,
    output reg [2:0] boot_mode_latched_r
);
    localparam [4:0] WR_MASK = `BUS_WR_MASK;
    localparam [4:0] ROM_MASK = `BUS_ROM_MASK;
    localparam [1:0] RS_IDLE = 2'h1;
    localparam [1:0] RS_WAIT = 2'h2;
    localparam NB = `NBUS;
    localparam NK = `RAM_BLOCKS;
    localparam WW = `RAM_WORD_W;

    // Quarter-wave sine, Q15 magnitudes for 0..90 degrees in 64 steps
    function [14:0] sine_quarter;
        input [6:0] q;
        begin
            case (q)
                7'h00: sine_quarter = 15'd0;
                7'h01: sine_quarter = 15'd804;
                7'h02: sine_quarter = 15'd1608;
                7'h03: sine_quarter = 15'd2410;
                7'h04: sine_quarter = 15'd3212;
                7'h05: sine_quarter = 15'd4011;
                7'h06: sine_quarter = 15'd4808;
                7'h07: sine_quarter = 15'd5602;
                7'h08: sine_quarter = 15'd6393;
                7'h09: sine_quarter = 15'd7179;
                7'h0A: sine_quarter = 15'd7962;
                7'h0B: sine_quarter = 15'd8739;
                7'h0C: sine_quarter = 15'd9512;
                7'h0D: sine_quarter = 15'd10278;
                7'h0E: sine_quarter = 15'd11039;
                7'h0F: sine_quarter = 15'd11793;
                7'h10: sine_quarter = 15'd12539;
                7'h11: sine_quarter = 15'd13279;
                7'h12: sine_quarter = 15'd14010;
                7'h13: sine_quarter = 15'd14732;
                7'h14: sine_quarter = 15'd15446;
                7'h15: sine_quarter = 15'd16151;
                7'h16: sine_quarter = 15'd16846;
                7'h17: sine_quarter = 15'd17530;
                7'h18: sine_quarter = 15'd18204;
                7'h19: sine_quarter = 15'd18868;
                7'h1A: sine_quarter = 15'd19519;
                7'h1B: sine_quarter = 15'd20159;
                7'h1C: sine_quarter = 15'd20787;
                7'h1D: sine_quarter = 15'd21403;
                7'h1E: sine_quarter = 15'd22005;
                7'h1F: sine_quarter = 15'd22594;
                7'h20: sine_quarter = 15'd23170;
                7'h21: sine_quarter = 15'd23731;
                7'h22: sine_quarter = 15'd24279;
                7'h23: sine_quarter = 15'd24811;
                7'h24: sine_quarter = 15'd25329;
                7'h25: sine_quarter = 15'd25832;
                7'h26: sine_quarter = 15'd26319;
                7'h27: sine_quarter = 15'd26790;
                7'h28: sine_quarter = 15'd27245;
                7'h29: sine_quarter = 15'd27683;
                7'h2A: sine_quarter = 15'd28105;
                7'h2B: sine_quarter = 15'd28510;
                7'h2C: sine_quarter = 15'd28898;
                7'h2D: sine_quarter = 15'd29268;
                7'h2E: sine_quarter = 15'd29621;
                7'h2F: sine_quarter = 15'd29956;
                7'h30: sine_quarter = 15'd30273;
                7'h31: sine_quarter = 15'd30572;
                7'h32: sine_quarter = 15'd30852;
                7'h33: sine_quarter = 15'd31113;
                7'h34: sine_quarter = 15'd31356;
                7'h35: sine_quarter = 15'd31580;
                7'h36: sine_quarter = 15'd31785;
                7'h37: sine_quarter = 15'd31971;
                7'h38: sine_quarter = 15'd32138;
                7'h39: sine_quarter = 15'd32285;
                7'h3A: sine_quarter = 15'd32412;
                7'h3B: sine_quarter = 15'd32521;
                7'h3C: sine_quarter = 15'd32609;
                7'h3D: sine_quarter = 15'd32678;
                7'h3E: sine_quarter = 15'd32728;
                7'h3F: sine_quarter = 15'd32757;
                default: sine_quarter = 15'd32767;
            endcase
        end
    endfunction

    // ROM image; loader code and vectors are not held, they read as fill
    function [15:0] rom_word;
        input [13:0] idx;
        reg [14:0] off;
        reg [14:0] d;
        reg [7:0] k;
        reg [6:0] q;
        reg [15:0] m;
        begin
            off = {idx, 1'b0};
            d = off - `ROM_OFF_SINE;
            k = d[8:1];
            q = k[6] ? (7'h40 - {1'b0, k[5:0]}) : {1'b0, k[5:0]};
            m = {1'b0, sine_quarter(q)};
            if (off >= `ROM_OFF_VEC) begin
                rom_word = `ROM_FILL_WORD;
            end else if (off >= `ROM_OFF_RSVD) begin
                rom_word = `ROM_RSVD_WORD;
            end else if (off >= `ROM_OFF_SINE) begin
                rom_word = k[7] ? (16'h0000 - m) : m;
            end else if (off >= `ROM_OFF_BRANCH) begin
                rom_word = BRANCH_BASE + {13'h0000, d[3:1]};
            end else if (off == `ROM_OFF_REV) begin
                rom_word = LOADER_REV;
            end else begin
                rom_word = `ROM_FILL_WORD;
            end
        end
    endfunction

    reg [NB-1:0] busy_r;
    reg [NB-1:0] ram_pend_r;
    reg [NB-1:0] ram_port_r;
    reg [NB*3-1:0] ram_blk_r;
    reg straps_taken_r;
    reg [1:0] rom_state_r;
    reg [1:0] rom_cnt_r;
    reg [2:0] rom_bus_r;
    reg [15:0] rom_word_r;
    reg [`AW-1:0] rom_last_r;
    reg [1:0] rom_seq_r;

    reg [NB-1:0] issue;
    reg [NB-1:0] bad;
    reg [NB-1:0] hit_ram;
    reg [NB-1:0] hit_rom;
    reg [NB-1:0] hit_ext;
    reg [`AW-1:0] a;
    reg wr;
    reg in_ram;
    reg in_rom;
    integer b, i, j, p;
    integer k;

    // Same decode for every bus: RAM page, ROM window, else external
    always @* begin
        issue = {NB{1'b0}};
        bad = {NB{1'b0}};
        hit_ram = {NB{1'b0}};
        hit_rom = {NB{1'b0}};
        hit_ext = {NB{1'b0}};
        a = {`AW{1'b0}};
        wr = 1'b0;
        in_ram = 1'b0;
        in_rom = 1'b0;
        for (b = 0; b < NB; b = b + 1) begin
            a = bus_addr[b*`AW +: `AW];
            wr = bus_we[b] & WR_MASK[b];
            issue[b] = bus_req[b] & ~busy_r[b] & ~bus_ack_r[b];
            in_ram = (a[23:16] == `RAM_PAGE);
            in_rom = ~rom_disable_select_r && (a[23:15] == `ROM_PAGE);
            bad[b] = issue[b] & ((in_rom & (wr | ~ROM_MASK[b]))
                | (in_ram & (b == `BUS_DMA) & dma_from_host_port
                & core_in_reset));
            hit_ram[b] = issue[b] & ~bad[b] & in_ram;
            hit_rom[b] = issue[b] & ~bad[b] & in_rom;
            hit_ext[b] = issue[b] & ~bad[b] & ~in_ram & ~in_rom;
        end
    end

    reg [NK-1:0] pa_en;
    reg [NK-1:0] pa_we;
    reg [NK*WW-1:0] pa_addr;
    reg [NK*16-1:0] pa_wd;
    reg [NK-1:0] pb_en;
    reg [NK-1:0] pb_we;
    reg [NK*WW-1:0] pb_addr;
    reg [NK*16-1:0] pb_wd;
    reg [NB-1:0] grant_ram;
    reg [NB-1:0] grant_b;
    reg [1:0] cnt;
    wire [NK*16-1:0] pa_rd;
    wire [NK*16-1:0] pb_rd;

    // Per block, the first two requesters by priority get ports A and B
    always @* begin
        pa_en = {NK{1'b0}};
        pa_we = {NK{1'b0}};
        pa_addr = {NK*WW{1'b0}};
        pa_wd = {NK*16{1'b0}};
        pb_en = {NK{1'b0}};
        pb_we = {NK{1'b0}};
        pb_addr = {NK*WW{1'b0}};
        pb_wd = {NK*16{1'b0}};
        grant_ram = {NB{1'b0}};
        grant_b = {NB{1'b0}};
        cnt = 2'h0;
        for (k = 0; k < NK; k = k + 1) begin
            cnt = 2'h0;
            for (j = 0; j < NB; j = j + 1) begin
                if (hit_ram[j] &&
                    (bus_addr[j*`AW+`RAM_BLK_LSB +: 3] == k)) begin
                    if (cnt == 2'h0) begin
                        pa_en[k] = 1'b1;
                        pa_we[k] = bus_we[j] & WR_MASK[j];
                        pa_addr[k*WW +: WW] =
                            bus_addr[j*`AW+`RAM_WORD_LSB +: WW];
                        pa_wd[k*16 +: 16] = bus_wdata[j*`DW +: `DW];
                        grant_ram[j] = 1'b1;
                    end else if (cnt == 2'h1) begin
                        pb_en[k] = 1'b1;
                        pb_we[k] = bus_we[j] & WR_MASK[j];
                        pb_addr[k*WW +: WW] =
                            bus_addr[j*`AW+`RAM_WORD_LSB +: WW];
                        pb_wd[k*16 +: 16] = bus_wdata[j*`DW +: `DW];
                        grant_ram[j] = 1'b1;
                        grant_b[j] = 1'b1;
                    end
                    if (cnt != 2'h2) begin
                        cnt = cnt + 2'h1;
                    end
                end
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NK; g = g + 1) begin : blk
            ram_block #(.AW(WW), .DW(16)) u_ram (
                .clk_sys(clk_sys),
                .a_en(pa_en[g]),
                .a_we(pa_we[g]),
                .a_addr(pa_addr[g*WW +: WW]),
                .a_wdata(pa_wd[g*16 +: 16]),
                .a_rdata_r(pa_rd[g*16 +: 16]),
                .b_en(pb_en[g]),
                .b_we(pb_we[g]),
                .b_addr(pb_addr[g*WW +: WW]),
                .b_wdata(pb_wd[g*16 +: 16]),
                .b_rdata_r(pb_rd[g*16 +: 16])
            );
        end
    endgenerate

    reg [2:0] rom_pick;
    reg rom_pick_v;
    reg [2:0] ext_pick;
    reg ext_pick_v;
    reg [NB*16-1:0] ram_rd;
    reg [`AW-1:0] rom_addr;
    reg [`AW-1:0] ext_addr;

    // Highest-priority winner for the ROM engine and the external path
    always @* begin
        rom_pick = 3'h0;
        rom_pick_v = 1'b0;
        ext_pick = 3'h0;
        ext_pick_v = 1'b0;
        ram_rd = {NB*16{1'b0}};
        for (p = NB - 1; p >= 0; p = p - 1) begin
            if (hit_rom[p]) begin
                rom_pick = p[2:0];
                rom_pick_v = 1'b1;
            end
            if (hit_ext[p]) begin
                ext_pick = p[2:0];
                ext_pick_v = 1'b1;
            end
            ram_rd[p*16 +: 16] = ram_port_r[p] ?
                pb_rd[ram_blk_r[p*3 +: 3]*16 +: 16] :
                pa_rd[ram_blk_r[p*3 +: 3]*16 +: 16];
        end
        rom_addr = bus_addr[rom_pick*`AW +: `AW];
        ext_addr = bus_addr[ext_pick*`AW +: `AW];
    end

    wire rom_take = rom_pick_v && (rom_state_r == RS_IDLE);
    wire rom_deliver = (rom_state_r == RS_WAIT) && (rom_cnt_r == 2'h0);
    // A sequence continues only on the next word soon after the last one
    wire rom_is_seq = (rom_seq_r != 2'h0)
        && (rom_addr == rom_last_r + `ROM_STEP);

    // ROM engine: one word at a time, first of a sequence is slower
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rom_state_r <= RS_IDLE;
            rom_cnt_r <= 2'h0;
            rom_bus_r <= 3'h0;
            rom_word_r <= 16'h0000;
            rom_last_r <= {`AW{1'b0}};
            rom_seq_r <= 2'h0;
        end else begin
            case (rom_state_r)
                RS_IDLE: begin
                    if (rom_take) begin
                        rom_state_r <= RS_WAIT;
                        rom_cnt_r <= rom_is_seq ? `ROM_SEQ_CYC
                            : `ROM_FIRST_CYC;
                        rom_bus_r <= rom_pick;
                        rom_word_r <= rom_word(rom_addr[14:1]);
                        rom_last_r <= rom_addr;
                    end else if (rom_seq_r != 2'h0) begin
                        rom_seq_r <= rom_seq_r - 2'h1;
                    end
                    if (soft_reset) begin
                        rom_seq_r <= 2'h0;
                    end
                end
                RS_WAIT: begin
                    if (rom_cnt_r == 2'h0) begin
                        rom_state_r <= RS_IDLE;
                        rom_seq_r <= `ROM_SEQ_GRACE;
                    end else begin
                        rom_cnt_r <= rom_cnt_r - 2'h1;
                    end
                end
                default: begin
                    rom_state_r <= RS_IDLE;
                end
            endcase
        end
    end

    // Strap capture on the first edge after release; no later sampling
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            straps_taken_r <= 1'b0;
            rom_disable_select_r <= `SEL_RESET;
            boot_mode_latched_r <= 3'h0;
        end else if (!straps_taken_r) begin
            straps_taken_r <= 1'b1;
            boot_mode_latched_r <= boot_mode_straps;
            rom_disable_select_r <= (boot_mode_straps == `STRAP_EXT16)
                || (boot_mode_straps == `STRAP_EXT32);
        end else if (core_status_word_three_wr) begin
            // Soft reset is deliberately not an input here
            rom_disable_select_r <= core_status_word_three_sel;
        end
    end

    // Per-bus completion, read data return and outstanding tracking
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            bus_ack_r <= {NB{1'b0}};
            bus_err_r <= {NB{1'b0}};
            bus_rdata_r <= {NB*`DW{1'b0}};
            busy_r <= {NB{1'b0}};
            ram_pend_r <= {NB{1'b0}};
            ram_port_r <= {NB{1'b0}};
            ram_blk_r <= {NB*3{1'b0}};
        end else begin
            for (i = 0; i < NB; i = i + 1) begin
                bus_ack_r[i] <= ram_pend_r[i] | bad[i]
                    | (rom_deliver && (rom_bus_r == i))
                    | (ext_ack && (ext_ack_tag == i));
                bus_err_r[i] <= bad[i];
                if (ram_pend_r[i]) begin
                    bus_rdata_r[i*`DW +: `DW] <= ram_rd[i*16 +: 16];
                end else if (rom_deliver && (rom_bus_r == i)) begin
                    bus_rdata_r[i*`DW +: `DW] <= rom_word_r;
                end else if (ext_ack && (ext_ack_tag == i)) begin
                    bus_rdata_r[i*`DW +: `DW] <= ext_rdata;
                end
                if (grant_ram[i] || (rom_take && (rom_pick == i))
                    || (ext_pick_v && (ext_pick == i))) begin
                    busy_r[i] <= 1'b1;
                end else if (ram_pend_r[i] || (rom_deliver
                    && (rom_bus_r == i)) || (ext_ack && (ext_ack_tag == i)))
                begin
                    busy_r[i] <= 1'b0;
                end
                ram_pend_r[i] <= grant_ram[i];
                ram_port_r[i] <= grant_b[i];
                ram_blk_r[i*3 +: 3] <= bus_addr[i*`AW+`RAM_BLK_LSB +: 3];
            end
        end
    end

    // External request: one pulse per forwarded access, tagged by bus
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ext_req_r <= 1'b0;
            ext_we_r <= 1'b0;
            ext_addr_r <= {`AW{1'b0}};
            ext_wdata_r <= {`DW{1'b0}};
            ext_tag_r <= 3'h0;
        end else begin
            ext_req_r <= ext_pick_v;
            if (ext_pick_v) begin
                ext_we_r <= bus_we[ext_pick] & WR_MASK[ext_pick];
                ext_addr_r <= ext_addr;
                ext_wdata_r <= bus_wdata[ext_pick*`DW +: `DW];
                ext_tag_r <= ext_pick;
            end
        end
    end
endmodule

/* File: ext_mem_model.sv */
// External memory path model: answers forwarded accesses, fast or slow
`timescale 1ns/1ps
module ext_mem_model(
    input wire clk_sys,
    input wire ext_req_r,
    input wire [23:0] ext_addr_r,
    input wire [2:0] ext_tag_r,
    output reg ext_ack,
    output reg [2:0] ext_ack_tag,
    output reg [15:0] ext_rdata
);
    reg [3:0] wait_r = 4'h0;
    reg slow_r = 1'h0;
    reg [15:0] word_r = 16'h0;
    initial begin
        ext_ack = 1'h0;
        ext_ack_tag = 3'h0;
        ext_rdata = 16'h0;
    end
    // Data is inverted each cycle off the ack cycle so a sample one cycle late never matches
    always @(posedge clk_sys) begin
        ext_ack <= 1'h0;
        ext_rdata <= ~ext_rdata;
        if (wait_r == 4'h1) begin
            ext_ack <= 1'h1;
            ext_rdata <= word_r;
        end
        if (wait_r != 4'h0) begin
            wait_r <= wait_r - 4'h1;
        end else if (ext_req_r) begin
            wait_r <= slow_r ? 4'h5 : 4'h1; // Alternate fast and slow
            slow_r <= ~slow_r;
            word_r <= ext_addr_r[15:0] ^ 16'hA5A5;
            ext_ack_tag <= ext_tag_r;
        end
    end
endmodule

/* File: mem_checker.sv */
// Port assertions for the on-chip memory decoder
`timescale 1ns/1ps
`include "mem_consts.vh"
module mem_checker(
    input wire clk_sys,
    input wire reset,
    input wire core_in_reset,
    input wire soft_reset,
    input wire [2:0] boot_mode_straps,
    input wire core_status_word_three_wr,
    input wire core_status_word_three_sel,
    input wire [`NBUS-1:0] bus_req,
    input wire [`NBUS*`AW-1:0] bus_addr,
    input wire dma_from_host_port,
    input wire [`NBUS-1:0] bus_ack_r,
    input wire [`NBUS-1:0] bus_err_r,
    input wire ext_req_r,
    input wire [`AW-1:0] ext_addr_r,
    input wire rom_disable_select_r,
    input wire [2:0] boot_mode_latched_r
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Strap capture and selector load at the first edge after release
    a_strap_capture: assert property ($past(reset) |=>
        boot_mode_latched_r == $past(boot_mode_straps)) else $error("capture");
    a_sel_from_straps: assert property ($past(reset) |=>
        rom_disable_select_r == ($past(boot_mode_straps) == 3'h0 ||
        $past(boot_mode_straps) == 3'h4)) else $error("strap select");
    a_straps_ignored: assert property (!$past(reset) &&
        !$past(reset, 2) |-> $stable(boot_mode_latched_r)) else $error("strap");
    // Software write of the selector, untouched by software reset
    a_sw_select: assert property (core_status_word_three_wr &&
        !$past(reset) |=> rom_disable_select_r ==
        $past(core_status_word_three_sel)) else $error("sw select");
    a_soft_keep: assert property (soft_reset &&
        !core_status_word_three_wr && !$past(reset) |=>
        $stable(rom_disable_select_r)) else $error("soft reset");
    a_host_refuse: assert property (bus_ack_r[4] &&
        $past(bus_req[4] && dma_from_host_port && core_in_reset) &&
        $past(bus_addr[119:112]) == `RAM_PAGE |-> bus_err_r[4])
        else $error("host port");
    a_rom_write_err: assert property (bus_ack_r[3] &&
        $past(bus_addr[95:87]) == `ROM_PAGE && !$past(rom_disable_select_r)
        |-> bus_err_r[3]) else $error("rom write");
    a_ext_not_ram: assert property (ext_req_r |->
        ext_addr_r[23:16] != `RAM_PAGE) else $error("ram forwarded");
    a_rom_first: assert property ($rose(bus_req[0]) &&
        bus_addr[23:0] == 24'hFF8000 && !rom_disable_select_r &&
        bus_req[2:1] == 2'h0 |-> !bus_ack_r[0] [*4] ##1 bus_ack_r[0])
        else $error("rom first");
    a_ram_two_cyc: assert property ($rose(bus_req[3]) &&
        bus_addr[95:88] == `RAM_PAGE && bus_req[2:1] == 2'h0 |->
        ##1 !bus_ack_r[3] ##1 bus_ack_r[3]) else $error("ram latency");
endmodule

/* File: tb_top.sv */
// Self-checking bench for the on-chip memory decoder
`timescale 1ns/1ps
`include "mem_consts.vh"
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin \
n_mismatch++; $display("Error %s exp %h got %h", n, e, a); end end
module tb_top;
    reg clk_sys = 1'h0, reset = 1'h1, core_in_reset = 1'h0;
    reg soft_reset = 1'h0, dma_from_host_port = 1'h0;
    reg core_status_word_three_wr = 1'h0, core_status_word_three_sel = 1'h0;
    reg [2:0] boot_mode_straps = 3'h4;
    reg [4:0] bus_req = 5'h0, bus_we = 5'h0;
    reg [119:0] bus_addr = 120'h0;
    reg [79:0] bus_wdata = 80'h0;
    wire [4:0] bus_ack_r, bus_err_r;
    wire [79:0] bus_rdata_r;
    wire ext_req_r, ext_we_r, ext_ack, rom_disable_select_r;
    wire [23:0] ext_addr_r;
    wire [15:0] ext_wdata_r, ext_rdata;
    wire [2:0] ext_tag_r, ext_ack_tag, boot_mode_latched_r;
    int n_mismatch = 0, check_count = 0;
    onchip_memory_decoder u_onchip_memory_decoder(.clk_sys, .reset,
        .core_in_reset, .soft_reset, .boot_mode_straps,
        .core_status_word_three_wr, .core_status_word_three_sel, .bus_req,
        .bus_we, .bus_addr, .bus_wdata, .dma_from_host_port, .bus_ack_r,
        .bus_err_r, .bus_rdata_r, .ext_req_r, .ext_we_r, .ext_addr_r,
        .ext_wdata_r, .ext_tag_r, .ext_ack, .ext_ack_tag, .ext_rdata,
        .rom_disable_select_r, .boot_mode_latched_r);
    ext_mem_model u_ext_mem_model(.clk_sys, .ext_req_r, .ext_addr_r,
        .ext_tag_r, .ext_ack, .ext_ack_tag, .ext_rdata);
    always #2.5 clk_sys = ~clk_sys;
    task automatic conclude;
        if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // One access, fields held until the completion pulse, then judged
    task automatic acc(input int b, input w, input [23:0] a,
        input [15:0] d, input [15:0] xq, input xe, input int xn);
        int n;
        begin
            n = 0;
            @(negedge clk_sys);
            bus_req[b] = 1'h1;
            bus_we[b] = w;
            bus_addr[b*24+:24] = a;
            bus_wdata[b*16+:16] = d;
            do begin
                @(negedge clk_sys);
                n++;
            end while (bus_ack_r[b] !== 1'h1 && n < 40);
            bus_req[b] = 1'h0;
            `CHK("ack", 1'h1, bus_ack_r[b])
            `CHK("err", xe, bus_err_r[b])
            if (!w && !xe) `CHK("rdata", xq, bus_rdata_r[b*16+:16])
            if (xn > 0) `CHK("latency", xn, n)
        end
    endtask
    task automatic hw_reset(input [2:0] s);
        boot_mode_straps = s;
        reset = 1'h1;
        repeat (2) @(negedge clk_sys);
        reset = 1'h0;
        repeat (2) @(negedge clk_sys);
    endtask
    // Straps 4 switch the ROM off; later strap moves are ignored
    task automatic t_straps_off;
        `CHK("sel", 1'h1, rom_disable_select_r)
        `CHK("straps", 3'h4, boot_mode_latched_r)
        boot_mode_straps = 3'h1;
        repeat (2) @(negedge clk_sys);
        `CHK("straps", 3'h4, boot_mode_latched_r)
        acc(0, 0, 24'hFF8000, 16'h0, 16'h25A5, 0, 0);
    endtask
    // Software switches the ROM on; reads of loader, sine and branch-table words, a refused write
    task automatic t_rom;
        core_status_word_three_wr = 1'h1;
        @(negedge clk_sys);
        core_status_word_three_wr = 1'h0;
        soft_reset = 1'h1;
        @(negedge clk_sys);
        soft_reset = 1'h0;
        `CHK("sel", 1'h0, rom_disable_select_r)
        acc(0, 0, 24'hFF8000, 16'h0, 16'h0, 0, 4);
        acc(0, 0, 24'hFF8002, 16'h0, 16'h0, 0, 2);
        acc(1, 0, 24'hFFED80, 16'h0, 16'h7FFF, 0, 0);
        acc(2, 0, 24'hFFECB6, 16'h0, 16'h0003, 0, 0);
        acc(3, 1, 24'hFF9000, 16'h55AA, 16'h0, 1, 1);
    endtask
    // One word per RAM block, then two accesses to one block together
    task automatic t_ram;
        for (int k = 0; k < 8; k++) begin
            acc(3, 1, 24'h002002 * k, 16'hC000 + k, 16'h0, 0, 2);
        end
        fork
            acc(0, 0, 24'h002002, 16'h0, 16'hC001, 0, 2);
            acc(3, 1, 24'h002004, 16'h1234, 16'h0, 0, 2);
        join
        acc(1, 0, 24'h00E00E, 16'h0, 16'hC007, 0, 2);
    endtask
    // Host-port DMA refused while the core is held in reset; other DMA still served
    task automatic t_host;
        core_in_reset = 1'h1;
        dma_from_host_port = 1'h1;
        acc(4, 0, 24'h002004, 16'h0, 16'h0, 1, 1);
        dma_from_host_port = 1'h0;
        acc(4, 0, 24'h002004, 16'h0, 16'h1234, 0, 2);
        core_in_reset = 1'h0;
    endtask
    // Outside addresses go out; the model answers slow then fast
    task automatic t_ext;
        acc(0, 0, 24'h010000, 16'h0, 16'hA5A5, 0, 0);
        acc(2, 0, 24'h123456, 16'h0, 16'h91F3, 0, 0);
        `CHK("ext", 24'h123456, ext_addr_r)
    endtask
    task automatic t_reset2;
        hw_reset(3'h2);
        `CHK("sel", 1'h0, rom_disable_select_r)
        `CHK("straps", 3'h2, boot_mode_latched_r)
        acc(0, 0, 24'hFF8000, 16'h0, 16'h0, 0, 4);
    endtask
    initial begin
        hw_reset(3'h4);
        t_straps_off;
        t_rom;
        t_ram;
        t_host;
        t_ext;
        t_reset2;
        conclude;
    end
    // The run needs some 90 cycles; this allows ample margin
    initial begin
        #20000;
        n_mismatch++;
        conclude;
    end
endmodule
bind onchip_memory_decoder mem_checker u_mem_checker(.clk_sys, .reset,
    .core_in_reset, .soft_reset, .boot_mode_straps,
    .core_status_word_three_wr, .core_status_word_three_sel, .bus_req,
    .bus_addr, .dma_from_host_port, .bus_ack_r, .bus_err_r, .ext_req_r,
    .ext_addr_r, .rom_disable_select_r, .boot_mode_latched_r);
